// ===== design/pts_sequencer.sv
/*
 privilege transfer sequencer: gate calls, returns,
 fast system entry and exit.
 assumes: request inputs stay stable while busy_o is
 high; memory answers each request with mem_ack_i.
*/
`timescale 1ns/10ps
`default_nettype none
module pts_sequencer
	import pts_pkg::*;
#(
	parameter int VA_BITS = 48
) (
	input  wire logic              core_clk_i,
	input  wire logic              reset_n_i,
	// request from the instruction stream
	input  wire logic              op_valid_i,
	input  wire pts_op_e           op_kind_i,
	input  wire logic              long_mode_i,
	input  wire logic              wide_operand_prefix_i,
	input  wire logic [1:0]        current_level_i,
	// caller context
	input  wire logic [15:0]       cur_code_sel_i,
	input  wire logic [63:0]       cur_ip_i,
	input  wire logic [15:0]       cur_stack_sel_i,
	input  wire logic [63:0]       cur_stack_ptr_i,
	input  wire logic [31:0]       code_limit_i,
	// gate and task state record
	input  wire logic [15:0]       gate_code_sel_i,
	input  wire logic [63:0]       gate_target_ip_i,
	input  wire logic [1:0]        gate_target_level_i,
	input  wire logic [4:0]        gate_param_count_i,
	input  wire logic [15:0]       task_stack_sel_i,
	input  wire logic [63:0]       task_stack_ptr_i,
	// return operands and checks
	input  wire logic [15:0]       rtn_byte_count_i,
	input  wire logic              desc_code_ok_i,
	input  wire logic              desc_stack_ok_i,
	input  wire logic              tgt_long_i,
	input  wire logic [1:0]        tgt_level_i,
	input  wire logic [15:0]       tgt_stack_sel_i,
	input  wire logic [7:0]        dseg_level_i,
	input  wire logic [3:0]        dseg_conf_i,
	// model registers and general registers
	input  wire logic [15:0]       entry_code_selector_reg_i,
	input  wire logic [63:0]       entry_pointer_reg_i,
	input  wire logic [63:0]       entry_stack_reg_i,
	input  wire logic [63:0]       wide_data_reg_i,
	input  wire logic [63:0]       wide_count_reg_i,
	// stack memory port
	output logic                   mem_req_o,
	output logic                   mem_we_o,
	output logic [63:0]            mem_addr_o,
	output logic [63:0]            mem_wdata_o,
	input  wire logic              mem_ack_i,
	input  wire logic [63:0]       mem_rdata_i,
	// results
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   fault_o,
	output logic [15:0]            code_sel_o,
	output logic [63:0]            ip_o,
	output logic [15:0]            stack_sel_o,
	output logic [63:0]            stack_ptr_o,
	output logic [1:0]             level_o,
	output logic                   long_code_o,
	output logic [31:0]            seg_base_o,
	output logic [31:0]            seg_limit_o,
	output logic                   ld_stack_desc_o,
	output logic [3:0]             dseg_null_o
);
	// ---------------------------------------------
	// state record
	// ---------------------------------------------
	typedef struct packed {
		pts_st_e     st;      // sequencer state
		logic [1:0]  idx;     // frame slot
		logic [63:0] wsp;     // working stack pointer
		logic [63:0] pop_ip;  // popped pointer
		logic [15:0] pop_cs;  // popped code selector
		logic [63:0] pop_sp;  // popped caller pointer
		logic [15:0] pop_ss;  // popped or new selector
		logic        busy;
		logic        done;
		logic        fault;
		logic        mreq;
		logic        mwe;
		logic [63:0] maddr;
		logic [63:0] mwdata;
		logic [15:0] o_cs;
		logic [63:0] o_ip;
		logic [15:0] o_ss;
		logic [63:0] o_sp;
		logic [1:0]  o_lvl;
		logic        o_long;
		logic [31:0] o_base;
		logic [31:0] o_limit;
		logic        o_ldss;
		logic [3:0]  o_dnull;
	} pts_state_s;

	pts_state_s q;          // registered state
	pts_state_s d;          // next state
	logic [63:0] step;      // stack word size
	logic [63:0] bcnt;      // return byte count
	logic        xlvl;      // return changes level
	logic        ss_null;   // popped stack selector null
	logic [3:0]  scrub;     // data segments to null

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	// upper address bits must copy the sign bit
	function automatic logic canon(input logic [63:0] a);
		logic [63:0] hi;
		hi = a >> (VA_BITS - 1);
		return (hi == '0) || (hi == (64'hffffffffffffffff >> (VA_BITS - 1)));
	endfunction

	// low half only, outside long mode or on a narrow fast exit
	function automatic logic [63:0] narrow(input logic [63:0] a);
		return {32'h0, a[NARROW_W-1:0]};
	endfunction

	// push data for each frame slot, outermost first
	function automatic logic [63:0] push_val(input logic [1:0] i,
		input logic [15:0] ss, input logic [63:0] sp,
		input logic [15:0] cs, input logic [63:0] ip);
		unique case (i)
			2'h0:    return {48'h0, ss};
			2'h1:    return sp;
			2'h2:    return {48'h0, cs};
			default: return ip;
		endcase
	endfunction

	assign step    = long_mode_i ? STEP_LONG : STEP_LEGACY;
	assign bcnt    = {48'h0, rtn_byte_count_i};
	assign xlvl    = q.pop_cs[LVL_HI:LVL_LO] > current_level_i;
	assign ss_null = q.pop_ss[SEL_W-1:IDX_LO] == NULL_IDX;

	// data segment levels against the new level
	pts_dseg_scrub #(
		.N_SEG       (4)
	) u_scrub (
		.new_level_i (q.pop_cs[LVL_HI:LVL_LO]),
		.seg_level_i (dseg_level_i),
		.seg_conf_i  (dseg_conf_i),
		.null_mask_o (scrub)
	);

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		d       = q;
		d.done  = 1'b0;
		d.fault = 1'b0;
		unique case (q.st)
			// accept a request
			ST_IDLE: begin
				if (op_valid_i) begin
					d.idx  = 2'h0;
					d.busy = 1'b1;
					unique case (op_kind_i)
						// gate call: stack switch, no parameter copy
						OP_CALL_GATE: begin
							if (long_mode_i) begin
								d.wsp    = entry_free_sp(task_stack_ptr_i);
								d.pop_ss = {NULL_IDX, gate_target_level_i};
							end else begin
								d.wsp    = narrow(task_stack_ptr_i);
								d.pop_ss = task_stack_sel_i;
							end
							d.maddr  = d.wsp - step;
							d.mwdata = push_val(2'h0, cur_stack_sel_i, cur_stack_ptr_i,
								cur_code_sel_i, cur_ip_i);
							d.mreq   = 1'b1;
							d.mwe    = 1'b1;
							d.st     = ST_PUSH;
						end
						// returns start popping at the stack top
						OP_NEAR_RTN, OP_FAR_RTN: begin
							d.wsp   = cur_stack_ptr_i;
							d.maddr = cur_stack_ptr_i;
							d.mreq  = 1'b1;
							d.mwe   = 1'b0;
							d.st    = ST_POP;
						end
						// null stack selector on interrupt return
						OP_INTR_SS: begin
							d.busy = 1'b0;
							if (tgt_stack_sel_i[SEL_W-1:IDX_LO] == NULL_IDX &&
								!(tgt_long_i && tgt_level_i != LVL_USER)) begin
								d.fault = 1'b1;
							end else begin
								d.done = 1'b1;
							end
						end
						// fast entry, no memory traffic at all
						OP_FAST_ENTRY: begin
							d.busy = 1'b0;
							if (long_mode_i && (entry_code_selector_reg_i[SEL_W-1:IDX_LO] ==
								NULL_IDX || !canon(entry_pointer_reg_i) ||
								!canon(entry_stack_reg_i))) begin
								d.fault = 1'b1;
							end else begin
								d.done    = 1'b1;
								d.o_cs    = entry_code_selector_reg_i;
								d.o_ss    = 16'(entry_code_selector_reg_i + ENT_SS_OFS);
								d.o_ip    = long_mode_i ? entry_pointer_reg_i :
									narrow(entry_pointer_reg_i);
								d.o_sp    = long_mode_i ? entry_stack_reg_i :
									narrow(entry_stack_reg_i);
								d.o_lvl   = LVL_TOP;
								d.o_long  = long_mode_i;
								d.o_base  = FLAT_BASE;
								d.o_limit = FLAT_LIMIT;
								d.o_ldss  = 1'b0;
								d.o_dnull = 4'h0;
							end
						end
						// fast exit, only from the top level
						OP_FAST_EXIT: begin
							d.busy = 1'b0;
							if (current_level_i != LVL_TOP) begin
								d.fault = 1'b1;
							end else if (long_mode_i && wide_operand_prefix_i) begin
								if (!canon(wide_data_reg_i) || !canon(wide_count_reg_i)) begin
									d.fault = 1'b1;
								end else begin
									d.done   = 1'b1;
									d.o_cs   = 16'(entry_code_selector_reg_i + EXW_CS_OFS);
									d.o_ss   = 16'(entry_code_selector_reg_i + EXW_SS_OFS);
									d.o_ip   = wide_data_reg_i;
									d.o_sp   = wide_count_reg_i;
									d.o_long = 1'b1;
								end
							end else begin
								d.done   = 1'b1;
								d.o_cs   = 16'(entry_code_selector_reg_i + EXT_CS_OFS);
								d.o_ss   = 16'(entry_code_selector_reg_i + EXT_SS_OFS);
								d.o_ip   = narrow(wide_data_reg_i);
								d.o_sp   = narrow(wide_count_reg_i);
								d.o_long = 1'b0;
							end
							if (d.done) begin
								d.o_lvl   = LVL_USER;
								d.o_base  = FLAT_BASE;
								d.o_limit = FLAT_LIMIT;
								d.o_ldss  = 1'b0;
								d.o_dnull = 4'h0;
							end
						end
						default: begin
							d.busy = 1'b0;
						end
					endcase
				end
			end
			// push the caller frame onto the new stack
			ST_PUSH: begin
				if (mem_ack_i) begin
					d.wsp = q.maddr;
					d.idx = 2'(q.idx + 2'h1);
					if (q.idx == 2'h3) begin
						d.mreq = 1'b0;
						d.mwe  = 1'b0;
						d.st   = ST_FIN;
					end else begin
						d.maddr  = q.maddr - step;
						d.mwdata = push_val(d.idx, cur_stack_sel_i, cur_stack_ptr_i,
							cur_code_sel_i, cur_ip_i);
					end
				end
			end
			// pop ip, cs, then caller sp and ss
			ST_POP: begin
				if (mem_ack_i) begin
					d.idx   = 2'(q.idx + 2'h1);
					d.wsp   = q.maddr + step;
					d.maddr = q.maddr + step;
					unique case (q.idx)
						2'h0:    d.pop_ip = long_mode_i ? mem_rdata_i : narrow(mem_rdata_i);
						2'h1:    d.pop_cs = mem_rdata_i[SEL_W-1:0];
						2'h2:    d.pop_sp = mem_rdata_i;
						default: d.pop_ss = mem_rdata_i[SEL_W-1:0];
					endcase
					if (op_kind_i == OP_NEAR_RTN || q.idx == 2'h3) begin
						d.mreq = 1'b0;
						d.st   = ST_FIN;
					end else if (q.idx == 2'h1) begin
						if (mem_rdata_i[LVL_HI:LVL_LO] < current_level_i) begin
							d.mreq  = 1'b0;
							d.busy  = 1'b0;
							d.fault = 1'b1;
							d.st    = ST_IDLE;
						end else if (mem_rdata_i[LVL_HI:LVL_LO] == current_level_i) begin
							d.mreq = 1'b0;
							d.st   = ST_FIN;
						end else begin
							d.maddr = q.maddr + step + bcnt;
							d.wsp   = d.maddr;
						end
					end
				end
			end
			// final checks and results
			ST_FIN: begin
				d.st   = ST_IDLE;
				d.busy = 1'b0;
				d.done = 1'b1;
				d.o_base  = FLAT_BASE;
				d.o_limit = FLAT_LIMIT;
				d.o_dnull = 4'h0;
				d.o_ldss  = 1'b0;
				unique case (op_kind_i)
					OP_CALL_GATE: begin
						d.o_cs   = gate_code_sel_i;
						d.o_ip   = gate_target_ip_i;
						d.o_ss   = q.pop_ss;
						d.o_sp   = q.wsp;
						d.o_lvl  = gate_target_level_i;
						d.o_long = long_mode_i;
						d.o_ldss = !long_mode_i;
					end
					OP_NEAR_RTN: begin
						if (q.pop_ip > {32'h0, code_limit_i}) begin
							d.done  = 1'b0;
							d.fault = 1'b1;
						end
						d.o_cs   = cur_code_sel_i;
						d.o_ip   = q.pop_ip;
						d.o_ss   = cur_stack_sel_i;
						d.o_sp   = q.wsp + bcnt;
						d.o_lvl  = current_level_i;
						d.o_long = long_mode_i;
					end
					default: begin
						if (!desc_code_ok_i || (xlvl && (ss_null ? !long_mode_i :
							!desc_stack_ok_i))) begin
							d.done  = 1'b0;
							d.fault = 1'b1;
						end
						d.o_cs   = q.pop_cs;
						d.o_ip   = q.pop_ip;
						d.o_lvl  = q.pop_cs[LVL_HI:LVL_LO];
						d.o_long = long_mode_i;
						if (xlvl) begin
							d.o_ss    = q.pop_ss;
							d.o_sp    = q.pop_sp + bcnt;
							d.o_ldss  = !ss_null;
							d.o_dnull = scrub;
						end else begin
							d.o_ss = cur_stack_sel_i;
							d.o_sp = q.wsp + bcnt;
						end
					end
				endcase
				if (d.fault) begin
					d.o_dnull = 4'h0;
					d.o_ldss  = 1'b0;
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase
	end

	// inner pointer in long mode is taken whole
	function automatic logic [63:0] entry_free_sp(input logic [63:0] a);
		return a;
	endfunction

	// ---------------------------------------------
	// state register
	// ---------------------------------------------
	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q    <= '0;
			q.st <= ST_IDLE;
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign mem_req_o       = q.mreq;
	assign mem_we_o        = q.mwe;
	assign mem_addr_o      = q.maddr;
	assign mem_wdata_o     = q.mwdata;
	assign busy_o          = q.busy;
	assign done_o          = q.done;
	assign fault_o         = q.fault;
	assign code_sel_o      = q.o_cs;
	assign ip_o            = q.o_ip;
	assign stack_sel_o     = q.o_ss;
	assign stack_ptr_o     = q.o_sp;
	assign level_o         = q.o_lvl;
	assign long_code_o     = q.o_long;
	assign seg_base_o      = q.o_base;
	assign seg_limit_o     = q.o_limit;
	assign ld_stack_desc_o = q.o_ldss;
	assign dseg_null_o     = q.o_dnull;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);

	logic idle_req;
	assign idle_req = q.st == ST_IDLE && op_valid_i;

	chk_exit_level: assert property (idle_req && op_kind_i == OP_FAST_EXIT &&
		current_level_i != LVL_TOP |=> fault_o && !done_o)
		else $error("fast exit above top level not faulted");
	chk_entry_ss: assert property (done_o && op_kind_i == OP_FAST_ENTRY |->
		stack_sel_o == 16'(code_sel_o + ENT_SS_OFS) && level_o == LVL_TOP)
		else $error("fast entry stack selector wrong");
	chk_exit_wide: assert property (done_o && op_kind_i == OP_FAST_EXIT &&
		long_mode_i && wide_operand_prefix_i |-> long_code_o &&
		code_sel_o == 16'(entry_code_selector_reg_i + EXW_CS_OFS))
		else $error("wide fast exit selector wrong");
	chk_exit_narrow: assert property (done_o && op_kind_i == OP_FAST_EXIT &&
		!wide_operand_prefix_i |-> !long_code_o && ip_o[63:32] == 32'h0)
		else $error("narrow fast exit not compatibility");
	chk_push_step: assert property (q.st == ST_PUSH && mem_ack_i && q.idx != 2'h3
		|=> mem_addr_o == $past(mem_addr_o) - step)
		else $error("push step wrong");
	chk_call_frame: assert property (done_o && op_kind_i == OP_CALL_GATE &&
		long_mode_i |-> stack_ptr_o == 64'(task_stack_ptr_i - FRM_SS - STEP_LONG))
		else $error("call frame size wrong");
	chk_call_null: assert property (done_o && op_kind_i == OP_CALL_GATE &&
		long_mode_i |-> stack_sel_o == {NULL_IDX, gate_target_level_i} && !ld_stack_desc_o)
		else $error("call stack selector not null");
	chk_near_limit: assert property (done_o && op_kind_i == OP_NEAR_RTN |->
		ip_o <= {32'h0, code_limit_i})
		else $error("near return beyond limit");
	chk_entry_flat: assert property (done_o && op_kind_i == OP_FAST_ENTRY |->
		seg_base_o == FLAT_BASE && seg_limit_o == FLAT_LIMIT)
		else $error("entry segments not flat");
	chk_intr_null: assert property (idle_req && op_kind_i == OP_INTR_SS &&
		tgt_stack_sel_i[SEL_W-1:IDX_LO] == NULL_IDX && tgt_level_i == LVL_USER
		|=> fault_o)
		else $error("null stack to level 3 accepted");
	chk_entry_quiet: assert property (idle_req && op_kind_i == OP_FAST_ENTRY
		|=> !mem_req_o [*2])
		else $error("fast entry touched memory");
	chk_rtn_up: assert property (done_o && op_kind_i == OP_FAR_RTN |->
		level_o >= current_level_i)
		else $error("return to more privileged level");

	cov_call: cover property (done_o && op_kind_i == OP_CALL_GATE);
	cov_rtn_x: cover property (done_o && op_kind_i == OP_FAR_RTN && level_o != current_level_i);
	cov_exit: cover property (done_o && op_kind_i == OP_FAST_EXIT);
endmodule
`default_nettype wire

// ===== design/pts_pkg.sv
/*
 constants and types of the privilege transfer sequencer.
 assumes: 64-bit stack words, 16-bit selectors.
*/
// Overview of operation
// - long gate call: inner pointer, null stack selector
// - frame: ip +0, cs +8, sp +16, ss +24
// - long mode pushes and pops move eight bytes
// - no parameter copy, gate count ignored
// - far return pops ss; null skips descriptor load
// - interrupt return null ss: long target, level not 3
// - near return checks only code limit
// - same-level far return pops cs, ip, checks
// - level change only toward larger requested level
// - far return checks code descriptor and level
// - byte count skips callee parameters
// - restore caller stack, check it, fault on limit; the code has no limit check, it faults on desc_stack_ok_i or a null selector outside long mode
// - byte count added again without limit check
// - null data segments below new level
// - entry at any level, exit only at 0
// - fast entry saves no return state
// - entry takes cs, ip, sp; ss is cs plus 8
// - legacy exit: cs plus 16, ss plus 24
// - wide entry regs, low half outside long mode
// - long entry forces flat code and stack
// - wide exit: plus 32 and 40, long bit set
// - narrow exit in long mode clears long bit
package pts_pkg;
	// ---------------------------------------------
	// widths and selector fields
	// ---------------------------------------------
	localparam int          SEL_W       = 16;
	localparam int          ADR_W       = 64;
	localparam int          LVL_LO      = 0;
	localparam int          LVL_HI      = 1;
	localparam int          IDX_LO      = 2;
	localparam int          NARROW_W    = 32;
	// ---------------------------------------------
	// stack steps and frame offsets
	// ---------------------------------------------
	localparam logic [63:0] STEP_LONG   = 64'h8;
	localparam logic [63:0] STEP_LEGACY = 64'h4;
	localparam logic [63:0] FRM_CS      = 64'h8;
	localparam logic [63:0] FRM_SP      = 64'h10;
	localparam logic [63:0] FRM_SS      = 64'h18;
	// ---------------------------------------------
	// fast entry and exit selector offsets
	// ---------------------------------------------
	localparam logic [15:0] ENT_SS_OFS  = 16'h8;
	localparam logic [15:0] EXT_CS_OFS  = 16'h10;
	localparam logic [15:0] EXT_SS_OFS  = 16'h18;
	localparam logic [15:0] EXW_CS_OFS  = 16'h20;
	localparam logic [15:0] EXW_SS_OFS  = 16'h28;
	// ---------------------------------------------
	// levels and flat segment attributes
	// ---------------------------------------------
	localparam logic [1:0]  LVL_TOP     = 2'h0;
	localparam logic [1:0]  LVL_USER    = 2'h3;
	localparam logic [31:0] FLAT_BASE   = 32'h0;
	localparam logic [31:0] FLAT_LIMIT  = 32'hffffffff;
	localparam logic [13:0] NULL_IDX    = 14'h0;
	// operations offered by the instruction stream
	typedef enum logic [2:0] {
		OP_CALL_GATE,
		OP_NEAR_RTN,
		OP_FAR_RTN,
		OP_INTR_SS,
		OP_FAST_ENTRY,
		OP_FAST_EXIT
	} pts_op_e;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PUSH,
		ST_POP,
		ST_FIN
	} pts_st_e;
endpackage

// ===== design/pts_dseg_scrub.sv
/*
 data segment scrub mask for a level-raising return.
 assumes: segment levels and kinds are stable inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module pts_dseg_scrub
	import pts_pkg::*;
#(
	parameter int N_SEG = 4
) (
	input  wire logic [1:0]         new_level_i,
	input  wire logic [2*N_SEG-1:0] seg_level_i,
	input  wire logic [N_SEG-1:0]   seg_conf_i,
	output logic      [N_SEG-1:0]   null_mask_o
);
	// ---------------------------------------------
	// one compare per segment register
	// ---------------------------------------------
	for (genvar g = 0; g < N_SEG; g++) begin : g_seg
		// conforming code is exempt
		assign null_mask_o[g] = !seg_conf_i[g] &&
			(seg_level_i[2*g+:2] < new_level_i);
	end
endmodule
`default_nettype wire

// ===== dv/pts_stack_mem.sv
/*
 stack memory model standing at the sequencer's memory port.
 assumes: each request is held until acknowledged.
*/
`timescale 1ns/10ps
`default_nettype none
module pts_stack_mem (
	input  wire logic        core_clk_i,
	input  wire logic [3:0]  lat_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [63:0] addr_i,
	input  wire logic [63:0] wdata_i,
	output var logic         ack_o,
	output var logic [63:0]  rdata_o
);
	logic [63:0] mem [logic [63:0]]; // sparse stack words
	logic [3:0]  wait_q;             // stall cycles so far
	int          n_wr;               // writes taken
	initial begin
		ack_o = 1'b0;
		rdata_o = '0;
		wait_q = '0;
		n_wr = 0;
	end
	// answer after lat_i stalls; read data churns when not valid
	always @(posedge core_clk_i) begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		wait_q <= '0;
		if (req_i && !ack_o && wait_q != lat_i) begin
			wait_q <= wait_q + 4'h1;
		end else if (req_i && !ack_o) begin
			ack_o <= 1'b1;
			rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~addr_i;
			if (we_i) begin
				mem[addr_i] = wdata_i;
				n_wr++;
			end
		end
	end
endmodule
`default_nettype wire

// ===== dv/tb_privilege_transfer_sequencer.sv
/*
 self-checking bench of the privilege transfer sequencer.
 assumes: pts_stack_mem answers the stack port.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_privilege_transfer_sequencer
	import pts_pkg::*;
;
	logic        core_clk_i, reset_n_i, op_valid_i, long_mode_i, wide_operand_prefix_i, tgt_long_i, flt;
	logic        mem_req_o, mem_we_o, mem_ack_i, busy_o, done_o, fault_o, long_code_o, ld_stack_desc_o;
	pts_op_e     op_kind_i;
	logic [1:0]  current_level_i, gate_target_level_i, tgt_level_i, level_o;
	logic [3:0]  dseg_conf_i, dseg_null_o, lat;
	logic [4:0]  gate_param_count_i;
	logic [7:0]  dseg_level_i;
	logic [15:0] cur_code_sel_i, cur_stack_sel_i, gate_code_sel_i, task_stack_sel_i, rtn_byte_count_i;
	logic        desc_code_ok_i, desc_stack_ok_i;
	logic [15:0] entry_code_selector_reg_i, code_sel_o, stack_sel_o;
	logic [31:0] code_limit_i, seg_base_o, seg_limit_o;
	logic [63:0] cur_ip_i, cur_stack_ptr_i, gate_target_ip_i, task_stack_ptr_i, entry_pointer_reg_i, ip_o;
	logic [63:0] entry_stack_reg_i, wide_data_reg_i, wide_count_reg_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [63:0] stack_ptr_o;
	int          n_fail, check_count, i;

	pts_sequencer #(.VA_BITS(48)) uut (.core_clk_i, .reset_n_i, .op_valid_i, .op_kind_i, .long_mode_i,
		.wide_operand_prefix_i, .current_level_i, .cur_code_sel_i, .cur_ip_i, .cur_stack_sel_i,
		.cur_stack_ptr_i, .code_limit_i, .gate_code_sel_i, .gate_target_ip_i, .gate_target_level_i,
		.gate_param_count_i, .task_stack_sel_i, .task_stack_ptr_i, .rtn_byte_count_i,
		.desc_code_ok_i, .desc_stack_ok_i, .tgt_long_i, .tgt_level_i, .tgt_stack_sel_i(16'h0),
		.dseg_level_i, .dseg_conf_i, .entry_code_selector_reg_i, .entry_pointer_reg_i, .entry_stack_reg_i,
		.wide_data_reg_i, .wide_count_reg_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i,
		.mem_rdata_i, .busy_o, .done_o, .fault_o, .code_sel_o, .ip_o, .stack_sel_o, .stack_ptr_o, .level_o,
		.long_code_o, .seg_base_o, .seg_limit_o, .ld_stack_desc_o, .dseg_null_o);
	pts_stack_mem u_mem (.core_clk_i, .lat_i(lat), .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
		.wdata_i(mem_wdata_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	// --------------------------------
	// clock and helper tasks
	// --------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one request pulse, bounded wait for done or fault
	task automatic run(input pts_op_e k);
		int n;
		@(posedge core_clk_i);
		op_kind_i <= k;
		op_valid_i <= 1'b1;
		@(posedge core_clk_i);
		op_valid_i <= 1'b0;
		for (n = 0; n < 80; n++) begin
			#1;
			if (done_o === 1'b1 || fault_o === 1'b1) break;
			@(posedge core_clk_i);
		end
		if (n == 80) begin
			n_fail++;
			end_sim();
		end
		flt = fault_o;
		@(posedge core_clk_i);
	endtask

	// --------------------------------
	// scenarios
	// --------------------------------
	initial begin
		{reset_n_i, op_valid_i, long_mode_i, wide_operand_prefix_i, tgt_long_i, lat} = '0;
		op_kind_i = OP_NEAR_RTN;
		{desc_code_ok_i, desc_stack_ok_i} = 2'h3;
		{current_level_i, gate_target_level_i, tgt_level_i, dseg_conf_i, gate_param_count_i, dseg_level_i} = '0;
		{cur_code_sel_i, cur_stack_sel_i, gate_code_sel_i, task_stack_sel_i, rtn_byte_count_i} = '0;
		{entry_code_selector_reg_i, code_limit_i, cur_ip_i, cur_stack_ptr_i, gate_target_ip_i} = '0;
		{task_stack_ptr_i, entry_pointer_reg_i, entry_stack_reg_i, wide_data_reg_i, wide_count_reg_i} = '0;
		n_fail = 0;
		check_count = 0;
		repeat (5) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		// long gate call from level 3, slow stack
		long_mode_i <= 1'b1;
		current_level_i <= 2'h3;
		cur_code_sel_i <= 16'h002b;
		cur_ip_i <= 64'h401000;
		cur_stack_sel_i <= 16'h0033;
		cur_stack_ptr_i <= 64'h7ff0;
		gate_code_sel_i <= 16'h0010;
		gate_target_ip_i <= 64'h1000;
		gate_target_level_i <= 2'h1;
		gate_param_count_i <= 5'h1f;
		task_stack_ptr_i <= 64'h9000;
		lat <= 4'h2;
		run(OP_CALL_GATE);
		cmp("frame ip", 64'h401000, u_mem.mem[64'h8fe0]);
		cmp("frame cs", 64'h2b, u_mem.mem[64'h8fe8]);
		cmp("frame sp", 64'h7ff0, u_mem.mem[64'h8ff0]);
		cmp("frame ss", 64'h33, u_mem.mem[64'h8ff8]);
		cmp("pushes", 64'h4, 64'(u_mem.n_wr));
		cmp("call sp", 64'h8fe0, stack_ptr_o);
		cmp("call ss", 16'h0001, stack_sel_o);
		cmp("call desc", 1'b0, ld_stack_desc_o);
		// cross-level far return with byte count, stored and null stack selector
		lat <= 4'h0;
		current_level_i <= 2'h0;
		cur_stack_ptr_i <= 64'h5000;
		rtn_byte_count_i <= 16'h0010;
		dseg_level_i <= 8'hcc;
		dseg_conf_i <= 4'h4;
		u_mem.mem[64'h5000] = 64'h1234;
		u_mem.mem[64'h5008] = 64'h002b;
		u_mem.mem[64'h5020] = 64'h7000;
		for (i = 0; i < 2; i++) begin
			u_mem.mem[64'h5028] = i ? 64'h0 : 64'h33;
			run(OP_FAR_RTN);
			cmp("rtn fault", 1'b0, flt);
			cmp("rtn ip", 64'h1234, ip_o);
			cmp("rtn level", 2'h3, level_o);
			cmp("rtn sp", 64'h7010, stack_ptr_o);
			cmp("rtn ss", i ? 16'h0 : 16'h0033, stack_sel_o);
			cmp("ss desc", i ? 1'b0 : 1'b1, ld_stack_desc_o);
			cmp("data null", 4'h1, dseg_null_o);
		end
		// refused stack descriptor, then refused code descriptor
		u_mem.mem[64'h5028] = 64'h33;
		for (i = 0; i < 2; i++) begin
			{desc_code_ok_i, desc_stack_ok_i} <= i ? 2'h1 : 2'h2;
			run(OP_FAR_RTN);
			cmp("bad desc", 1'b1, flt);
		end
		{desc_code_ok_i, desc_stack_ok_i} <= 2'h3;
		// return toward a more privileged level is refused
		current_level_i <= 2'h3;
		u_mem.mem[64'h5008] = 64'h0010;
		run(OP_FAR_RTN);
		cmp("inward rtn", 1'b1, flt);
		// near return at and past the code limit
		code_limit_i <= 32'h1234;
		for (i = 0; i < 2; i++) begin
			u_mem.mem[64'h5000] = 64'h1234 + 64'(i);
			run(OP_NEAR_RTN);
			cmp("near fault", 64'(i), flt);
		end
		// fast entry from level 3, legacy then long
		entry_code_selector_reg_i <= 16'h0010;
		entry_pointer_reg_i <= 64'hffff800000002000;
		entry_stack_reg_i <= 64'hffff800000003000;
		for (i = 0; i < 2; i++) begin
			long_mode_i <= i[0];
			run(OP_FAST_ENTRY);
			cmp("entry cs", 16'h0010, code_sel_o);
			cmp("entry ss", 16'h0018, stack_sel_o);
			cmp("entry ip", i ? 64'hffff800000002000 : 64'h2000, ip_o);
			cmp("entry sp", i ? 64'hffff800000003000 : 64'h3000, stack_ptr_o);
			cmp("entry level", 2'h0, level_o);
			cmp("entry busy", 1'b0, busy_o);
		end
		cmp("flat base", 32'h0, seg_base_o);
		cmp("flat limit", 32'hffffffff, seg_limit_o);
		cmp("no save", 64'h4, 64'(u_mem.n_wr));
		// fast exit: wide, narrow long, legacy; then from level 2
		current_level_i <= 2'h0;
		wide_data_reg_i <= 64'h00007fff00001000;
		wide_count_reg_i <= 64'h00007fff00002000;
		for (i = 0; i < 3; i++) begin
			long_mode_i <= (i < 2);
			wide_operand_prefix_i <= (i == 0);
			run(OP_FAST_EXIT);
			cmp("exit cs", i ? 16'h0020 : 16'h0030, code_sel_o);
			cmp("exit ss", i ? 16'h0028 : 16'h0038, stack_sel_o);
			cmp("exit ip", i ? 64'h1000 : 64'h00007fff00001000, ip_o);
			cmp("exit sp", i ? 64'h2000 : 64'h00007fff00002000, stack_ptr_o);
			if (i < 2) cmp("long bit", (i == 0), long_code_o);
		end
		current_level_i <= 2'h2;
		run(OP_FAST_EXIT);
		cmp("exit fault", 1'b1, flt);
		// null stack selector on interrupt return
		tgt_long_i <= 1'b1;
		for (i = 0; i < 2; i++) begin
			tgt_level_i <= i ? 2'h3 : 2'h0;
			run(OP_INTR_SS);
			cmp("null ss", 64'(i), flt);
		end
		end_sim();
	end
endmodule
`default_nettype wire
